// File: design/interrupt_vector_priority_logic.v
// interrupt arbitration and vector address generation for the core
`timescale 1ns/1ps
`default_nettype none
`include "irq_vector_defines.vh"

// Operation
// - vector is base plus per-source offset
// - six level-3 sources at offsets 0x00-0x0a
// - level-3 unmaskable, others maskable levels 0-2
// - level-3 order reset down to nmi
// - external a-d first, then dma 0-5
// - host command, transmit empty, receive full
// - serial port 0 fixed internal order
// - serial port 1 directly below port 0
// - async port then timers, timer2 compare last
// - serial port 0 offsets 0x30-0x3a
// - serial port 1 offsets 0x40-0x4a
// - async port offsets 0x50-0x58
module interrupt_vector_priority_logic (
  // clock and reset
  input wire core_clk_in,
  input wire rstn_in,
  // vector base from the core
  input wire [`ADDR_W-1:0] vector_base_address_in,
  // level-3 requests
  input wire hw_reset_req_in,
  input wire stack_error_req_in,
  input wire illegal_instr_req_in,
  input wire debug_req_in,
  input wire trap_req_in,
  input wire nmi_req_in,
  // external request pins, active high after pin logic
  input wire external_request_a_in,
  input wire external_request_b_in,
  input wire external_request_c_in,
  input wire external_request_d_in,
  // dma channels, bit n is channel n
  input wire [5:0] dma_req_in,
  // host port
  input wire host_cmd_req_in,
  input wire host_tx_empty_req_in,
  input wire host_rx_full_req_in,
  // serial ports: bit0 rx, 1 rx exc, 2 rx last, 3 tx, 4 tx exc, 5 tx last
  input wire [5:0] sync_serial_port_0_req_in,
  input wire [5:0] sync_serial_port_1_req_in,
  // async port: bit0 rx, 1 rx exc, 2 tx, 3 idle, 4 timer
  input wire [4:0] async_serial_port_req_in,
  // timers: bit 2n compare n, bit 2n+1 overflow n
  input wire [5:0] timer_req_in,
  // mask and level per maskable source, by priority index
  input wire [`NUM_MASKABLE-1:0] source_enable_in,
  input wire [2*`NUM_MASKABLE-1:0] interrupt_priority_level_in,
  // winning request to the core sequencer
  output reg irq_valid_out,
  output reg [`ADDR_W-1:0] irq_vector_out,
  output reg [1:0] irq_level_out,
  output reg irq_fixed_out,
  output reg [5:0] irq_source_out
);

  // ==========================================================
  // helpers

  // all arbitration settles within one cycle;
  // the single output register is the only latency
  // lowest set index wins; bit 6 flags a hit
  function [6:0] first_set;
    input [`NUM_MASKABLE-1:0] v;
    integer i;
    begin
      first_set = 7'h00;
      // scan high to low so the lowest index hit is kept last
      for (i = `NUM_MASKABLE - 1; i >= 0; i = i - 1) begin
        if (v[i]) begin
          first_set = {1'b1, i[5:0]};
        end
      end
    end
  endfunction

  // step n slots of two words from a group base
  function [7:0] slot;
    input [7:0] base;
    input [2:0] n;
    begin
      // stays within eight bits, no group reaches past 0x0a from its base
      slot = base + ({5'h00, n} << 1);
    end
  endfunction

  // offset of a maskable source by priority index;
  // reserved offsets are never produced
  // (0x0c, 0x0e, 0x3c, 0x3e, 0x4c, 0x4e, 0x5a to 0x5e, 0x66 and up);
  // rank order and offset order differ inside most groups
  function [7:0] maskable_offset;
    input [5:0] idx;
    begin
      case (idx)
        6'h00: maskable_offset = slot(`OFS_EXT_BASE, 3'h0);
        6'h01: maskable_offset = slot(`OFS_EXT_BASE, 3'h1);
        6'h02: maskable_offset = slot(`OFS_EXT_BASE, 3'h2);
        6'h03: maskable_offset = slot(`OFS_EXT_BASE, 3'h3);
        6'h04: maskable_offset = slot(`OFS_DMA_BASE, 3'h0);
        6'h05: maskable_offset = slot(`OFS_DMA_BASE, 3'h1);
        6'h06: maskable_offset = slot(`OFS_DMA_BASE, 3'h2);
        6'h07: maskable_offset = slot(`OFS_DMA_BASE, 3'h3);
        6'h08: maskable_offset = slot(`OFS_DMA_BASE, 3'h4);
        6'h09: maskable_offset = slot(`OFS_DMA_BASE, 3'h5);
        6'h0a: maskable_offset = `OFS_HOST_CMD;
        6'h0b: maskable_offset = `OFS_HOST_TX_EMPTY;
        6'h0c: maskable_offset = `OFS_HOST_RX_FULL;
        // serial port 0 in rank order
        6'h0d: maskable_offset = slot(`OFS_SSP0_BASE, 3'h1);
        6'h0e: maskable_offset = slot(`OFS_SSP0_BASE, 3'h0);
        6'h0f: maskable_offset = slot(`OFS_SSP0_BASE, 3'h2);
        6'h10: maskable_offset = slot(`OFS_SSP0_BASE, 3'h4);
        6'h11: maskable_offset = slot(`OFS_SSP0_BASE, 3'h5);
        6'h12: maskable_offset = slot(`OFS_SSP0_BASE, 3'h3);
        6'h13: maskable_offset = slot(`OFS_SSP1_BASE, 3'h1);
        6'h14: maskable_offset = slot(`OFS_SSP1_BASE, 3'h0);
        6'h15: maskable_offset = slot(`OFS_SSP1_BASE, 3'h2);
        6'h16: maskable_offset = slot(`OFS_SSP1_BASE, 3'h4);
        6'h17: maskable_offset = slot(`OFS_SSP1_BASE, 3'h5);
        6'h18: maskable_offset = slot(`OFS_SSP1_BASE, 3'h3);
        6'h19: maskable_offset = slot(`OFS_ASP_BASE, 3'h1);
        6'h1a: maskable_offset = slot(`OFS_ASP_BASE, 3'h0);
        6'h1b: maskable_offset = slot(`OFS_ASP_BASE, 3'h2);
        6'h1c: maskable_offset = slot(`OFS_ASP_BASE, 3'h3);
        6'h1d: maskable_offset = slot(`OFS_ASP_BASE, 3'h4);
        6'h1e: maskable_offset = slot(`OFS_TIMER_BASE, 3'h1);
        6'h1f: maskable_offset = slot(`OFS_TIMER_BASE, 3'h0);
        6'h20: maskable_offset = slot(`OFS_TIMER_BASE, 3'h3);
        6'h21: maskable_offset = slot(`OFS_TIMER_BASE, 3'h2);
        6'h22: maskable_offset = slot(`OFS_TIMER_BASE, 3'h5);
        6'h23: maskable_offset = slot(`OFS_TIMER_BASE, 3'h4);
        default: maskable_offset = `OFS_HW_RESET;
      endcase
    end
  endfunction

  // fixed sources need no mask and no level input
  // offset of a level-3 source by rank
  function [7:0] fixed_offset;
    input [5:0] idx;
    begin
      case (idx)
        6'h00: fixed_offset = `OFS_HW_RESET;
        6'h01: fixed_offset = `OFS_STACK_ERR;
        6'h02: fixed_offset = `OFS_ILLEGAL;
        6'h03: fixed_offset = `OFS_DEBUG;
        6'h04: fixed_offset = `OFS_TRAP;
        default: fixed_offset = `OFS_NMI;
      endcase
    end
  endfunction

  // ==========================================================
  // request vectors in priority order, index 0 highest

  // pin and port bit orders are remapped once into rank order;
  // everything below works on the rank index only
  wire [`NUM_FIXED-1:0] fixed_req;
  wire [`NUM_MASKABLE-1:0] maskable_req;

  assign fixed_req = {nmi_req_in, trap_req_in, debug_req_in,
                      illegal_instr_req_in, stack_error_req_in, hw_reset_req_in};

  // external pins then dma in channel order
  // host command, tx empty, rx full
  // port 0: rx exc, rx, rx last, tx exc, tx last, tx
  // port 1 in the same order below port 0
  // async port then timers, overflow first
  assign maskable_req = {
    timer_req_in[4], timer_req_in[5], timer_req_in[2], timer_req_in[3],
    timer_req_in[0], timer_req_in[1],
    async_serial_port_req_in[4], async_serial_port_req_in[3],
    async_serial_port_req_in[2], async_serial_port_req_in[0],
    async_serial_port_req_in[1],
    sync_serial_port_1_req_in[3], sync_serial_port_1_req_in[5],
    sync_serial_port_1_req_in[4], sync_serial_port_1_req_in[2],
    sync_serial_port_1_req_in[0], sync_serial_port_1_req_in[1],
    sync_serial_port_0_req_in[3], sync_serial_port_0_req_in[5],
    sync_serial_port_0_req_in[4], sync_serial_port_0_req_in[2],
    sync_serial_port_0_req_in[0], sync_serial_port_0_req_in[1],
    host_rx_full_req_in, host_tx_empty_req_in, host_cmd_req_in,
    dma_req_in,
    external_request_d_in, external_request_c_in,
    external_request_b_in, external_request_a_in};

  // ==========================================================
  // split enabled maskable requests by level

  // one row per level, rank order kept
  reg [`NUM_MASKABLE-1:0] at_level0;
  reg [`NUM_MASKABLE-1:0] at_level1;
  reg [`NUM_MASKABLE-1:0] at_level2;
  integer k;

  // dropping code 3 quietly is cheaper than an error flag
  // mask gates only maskable sources; code 3 is not a valid
  // programmed level, so such a source never competes
  always @* begin
    at_level0 = {`NUM_MASKABLE{1'b0}};
    at_level1 = {`NUM_MASKABLE{1'b0}};
    at_level2 = {`NUM_MASKABLE{1'b0}};
    for (k = 0; k < `NUM_MASKABLE; k = k + 1) begin
      if (maskable_req[k] && source_enable_in[k]) begin
        case (interrupt_priority_level_in[2*k +: 2])
          2'h0: at_level0[k] = 1'b1;
          2'h1: at_level1[k] = 1'b1;
          2'h2: at_level2[k] = 1'b1;
          default: at_level2[k] = 1'b0;
        endcase
      end
    end
  end

  // ==========================================================
  // arbitration

  // four parallel encoders, then a short chain over the levels;
  // trades some area for a shallow path
  // bit 6 of each winner flags a hit, bits 5:0 give the rank
  wire [6:0] win_fixed;
  wire [6:0] win_l2;
  wire [6:0] win_l1;
  wire [6:0] win_l0;

  assign win_fixed = first_set({{(`NUM_MASKABLE-`NUM_FIXED){1'b0}}, fixed_req});
  assign win_l2 = first_set(at_level2);
  assign win_l1 = first_set(at_level1);
  assign win_l0 = first_set(at_level0);

  // next values of the output flops
  reg next_valid;
  reg next_fixed;
  reg [1:0] next_level;
  reg [5:0] next_source;
  reg [7:0] next_offset;

  // level 3 beats any programmed level;
  // the defaults describe the idle case: base plus zero, source 0
  // highest level with a request wins
  always @* begin
    next_valid = 1'b1;
    next_fixed = 1'b0;
    next_level = `LEVEL_RESET;
    next_source = `SOURCE_RESET;
    next_offset = `OFS_HW_RESET;
    if (win_fixed[6]) begin
      next_fixed = 1'b1;
      next_level = `LEVEL_FIXED;
      next_source = win_fixed[5:0];
      next_offset = fixed_offset(win_fixed[5:0]);
    end else if (win_l2[6]) begin
      next_level = 2'h2;
      next_source = win_l2[5:0];
      next_offset = maskable_offset(win_l2[5:0]);
    end else if (win_l1[6]) begin
      next_level = 2'h1;
      next_source = win_l1[5:0];
      next_offset = maskable_offset(win_l1[5:0]);
    end else if (win_l0[6]) begin
      next_source = win_l0[5:0];
      next_offset = maskable_offset(win_l0[5:0]);
    end else begin
      next_valid = 1'b0;
    end
  end

  // ==========================================================
  // registered outputs, one cycle behind the requests

  // no acknowledge exists: a request shows while its source holds it,
  // so the core must qualify the vector with valid;
  // a base change takes effect one cycle later, like the requests
  // vector = base plus offset, wraps within the address width
  always @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      irq_valid_out <= 1'b0;
      irq_vector_out <= `VECTOR_RESET;
      irq_level_out <= `LEVEL_RESET;
      irq_fixed_out <= 1'b0;
      irq_source_out <= `SOURCE_RESET;
    end else begin
      irq_valid_out <= next_valid;
      irq_vector_out <= vector_base_address_in + {16'h0000, next_offset};
      irq_level_out <= next_level;
      irq_fixed_out <= next_fixed;
      irq_source_out <= next_source;
    end
  end

endmodule // interrupt_vector_priority_logic
`default_nettype wire

// File: design/irq_vector_defines.vh
// constants for the interrupt vector and priority logic
`ifndef IRQ_VECTOR_DEFINES_VH
`define IRQ_VECTOR_DEFINES_VH

// ==========================================================
// sizes
`define ADDR_W 24
`define NUM_MASKABLE 36
`define NUM_FIXED 6
`define LEVEL_FIXED 2'h3
`define LEVEL_MAX_PROG 2'h2

// ==========================================================
// level-3 vector offsets
`define OFS_HW_RESET 8'h00
`define OFS_STACK_ERR 8'h02
`define OFS_ILLEGAL 8'h04
`define OFS_DEBUG 8'h06
`define OFS_TRAP 8'h08
`define OFS_NMI 8'h0a

// ==========================================================
// maskable vector offsets (group bases, two-word spacing)
`define OFS_EXT_BASE 8'h10
`define OFS_DMA_BASE 8'h18
`define OFS_TIMER_BASE 8'h24
`define OFS_SSP0_BASE 8'h30
`define OFS_SSP1_BASE 8'h40
`define OFS_ASP_BASE 8'h50
`define OFS_HOST_RX_FULL 8'h60
`define OFS_HOST_TX_EMPTY 8'h62
`define OFS_HOST_CMD 8'h64
`define OFS_STEP 8'h02

// ==========================================================
// priority index of the first source of each maskable group
`define IDX_EXT 6'h00
`define IDX_DMA 6'h04
`define IDX_HOST 6'h0a
`define IDX_SSP0 6'h0d
`define IDX_SSP1 6'h13
`define IDX_ASP 6'h19
`define IDX_TIMER 6'h1e

// ==========================================================
// reset values
`define VECTOR_RESET 24'h000000
`define SOURCE_RESET 6'h00
`define LEVEL_RESET 2'h0

`endif

// File: verification/irq_priority_monitor.sv
// assertion checker for the interrupt vector and priority logic
`timescale 1ns/1ps
`default_nettype none
module irq_priority_monitor (
  // clock and reset
  input wire logic core_clk_in, rstn_in,
  // requests, enables, levels and base
  input wire logic hw_reset_req_in, stack_error_req_in, illegal_instr_req_in,
  input wire logic debug_req_in, trap_req_in, nmi_req_in, external_request_a_in,
  input wire logic [23:0] vector_base_address_in,
  input wire logic [35:0] source_enable_in,
  input wire logic [71:0] interrupt_priority_level_in,
  // winning request
  input wire logic irq_valid_out, irq_fixed_out,
  input wire logic [23:0] irq_vector_out,
  input wire logic [1:0] irq_level_out,
  input wire logic [5:0] irq_source_out
);
  // ==========================================================
  // properties; $past(rstn_in) hides the edge right after reset
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rstn_in);
  wire logic [5:0] fx = {nmi_req_in, trap_req_in, debug_req_in,
    illegal_instr_req_in, stack_error_req_in, hw_reset_req_in};
  wire logic win = irq_valid_out && !irq_fixed_out;
  reset_first_a: assert property ($past(rstn_in) && $past(hw_reset_req_in) |->
    irq_fixed_out && irq_source_out == 6'h00 && irq_vector_out == $past(vector_base_address_in))
    else $error("reset request not at base");
  nmi_last_a: assert property ($past(rstn_in) && $past(fx == 6'h20) |->
    irq_source_out == 6'h05 && irq_vector_out == $past(vector_base_address_in) + 24'h00000a)
    else $error("nmi vector wrong");
  fixed_level_a: assert property (irq_fixed_out |->
    irq_valid_out && irq_level_out == 2'h3 && irq_source_out < 6'h06)
    else $error("fixed winner not level 3");
  unmaskable_a: assert property ($past(rstn_in) && $past(|fx) |-> irq_fixed_out)
    else $error("level 3 request lost");
  masked_quiet_a: assert property ($past(rstn_in) &&
    $past(fx == 6'h00 && source_enable_in == 36'h0) |-> !irq_valid_out)
    else $error("masked request shown");
  level_match_a: assert property (win |-> irq_level_out != 2'h3 &&
    irq_level_out == 2'($past(interrupt_priority_level_in) >> (2 * irq_source_out)))
    else $error("winner level wrong");
  ext_a_top_a: assert property ($past(rstn_in) && $past(fx == 6'h00 &&
    external_request_a_in && source_enable_in[0] && interrupt_priority_level_in[1:0] == 2'h2)
    |-> irq_source_out == 6'h00 && irq_vector_out == $past(vector_base_address_in) + 24'h10)
    else $error("request a not first");
  host_cmd_a: assert property (win && irq_source_out == 6'h0a |->
    irq_vector_out == $past(vector_base_address_in) + 24'h000064)
    else $error("host command vector wrong");
  ssp0_exc_a: assert property (win && irq_source_out == 6'h0d |->
    irq_vector_out == $past(vector_base_address_in) + 24'h000032)
    else $error("serial rx exception vector wrong");
  timer2_cmp_a: assert property (win && irq_source_out == 6'h23 |->
    irq_vector_out == $past(vector_base_address_in) + 24'h00002c)
    else $error("timer 2 compare vector wrong");
  // main scenarios reached
  cover property (irq_fixed_out && irq_source_out == 6'h05);
  cover property (win && irq_level_out == 2'h0);
  cover property ($fell(irq_fixed_out) && irq_valid_out);
endmodule // irq_priority_monitor
bind interrupt_vector_priority_logic irq_priority_monitor irq_priority_monitor_i (
  .core_clk_in(core_clk_in), .rstn_in(rstn_in), .hw_reset_req_in(hw_reset_req_in),
  .stack_error_req_in(stack_error_req_in), .illegal_instr_req_in(illegal_instr_req_in),
  .debug_req_in(debug_req_in), .trap_req_in(trap_req_in), .nmi_req_in(nmi_req_in),
  .external_request_a_in(external_request_a_in), .source_enable_in(source_enable_in),
  .vector_base_address_in(vector_base_address_in), .irq_valid_out(irq_valid_out),
  .interrupt_priority_level_in(interrupt_priority_level_in), .irq_fixed_out(irq_fixed_out),
  .irq_vector_out(irq_vector_out), .irq_level_out(irq_level_out),
  .irq_source_out(irq_source_out));
`default_nettype wire

// File: verification/core_sequencer_model.sv
// core sequencer model that takes each presented vector
`timescale 1ns/1ps
`default_nettype none
module core_sequencer_model (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rstn_in,
  // winning request
  input wire logic irq_valid_in,
  input wire logic [23:0] irq_vector_in,
  // last vector taken
  output var logic [23:0] taken_vector_out,
  output var int taken_count_out
);
  // no acknowledge exists, so the core takes whatever is valid
  always @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      taken_vector_out <= 24'h000000;
      taken_count_out <= 0;
    end else if (irq_valid_in) begin
      taken_vector_out <= irq_vector_in;
      taken_count_out <= taken_count_out + 1;
    end
  end
endmodule // core_sequencer_model
`default_nettype wire

// File: verification/test_interrupt_vector_priority_logic.sv
// self-checking bench for the interrupt vector and priority logic
`timescale 1ns/1ps
`default_nettype none
module test_interrupt_vector_priority_logic;
  logic core_clk_in = 0;
  logic rstn_in = 0;
  logic [23:0] base = 0;
  logic [5:0] fx = 0, dma = 0, s0 = 0, s1 = 0, tmr = 0;
  logic [3:0] ext = 0;
  logic [2:0] host = 0;
  logic [4:0] asp = 0;
  logic [35:0] en = 0;
  logic [71:0] lvl = 0;
  logic [33:0] expect_word = 0;
  wire logic valid, fixed;
  wire logic [23:0] vec, taken;
  wire logic [1:0] level;
  wire logic [5:0] src;
  int n_errors = 0, n_tests = 0, cyc = 0, takes;
  logic [7:0] ofs [36] = '{8'h10, 8'h12, 8'h14, 8'h16, 8'h18, 8'h1a, 8'h1c, 8'h1e, 8'h20,
    8'h22, 8'h64, 8'h62, 8'h60, 8'h32, 8'h30, 8'h34, 8'h38, 8'h3a, 8'h36, 8'h42, 8'h40,
    8'h44, 8'h48, 8'h4a, 8'h46, 8'h52, 8'h50, 8'h54, 8'h56, 8'h58, 8'h26, 8'h24, 8'h2a,
    8'h28, 8'h2e, 8'h2c};
  // requests in priority order, index 0 highest
  wire logic [35:0] req = {tmr[4], tmr[5], tmr[2], tmr[3], tmr[0], tmr[1], asp[4:2], asp[0],
    asp[1], s1[3], s1[5], s1[4], s1[2], s1[0], s1[1], s0[3], s0[5], s0[4], s0[2], s0[0],
    s0[1], host[2], host[1], host[0], dma, ext};
  interrupt_vector_priority_logic interrupt_vector_priority_logic_i (
    .core_clk_in(core_clk_in), .rstn_in(rstn_in), .vector_base_address_in(base),
    .hw_reset_req_in(fx[0]), .stack_error_req_in(fx[1]), .illegal_instr_req_in(fx[2]),
    .debug_req_in(fx[3]), .trap_req_in(fx[4]), .nmi_req_in(fx[5]),
    .external_request_a_in(ext[0]), .external_request_b_in(ext[1]),
    .external_request_c_in(ext[2]), .external_request_d_in(ext[3]), .dma_req_in(dma),
    .host_cmd_req_in(host[0]), .host_tx_empty_req_in(host[1]), .host_rx_full_req_in(host[2]),
    .sync_serial_port_0_req_in(s0), .sync_serial_port_1_req_in(s1),
    .async_serial_port_req_in(asp), .timer_req_in(tmr), .source_enable_in(en),
    .interrupt_priority_level_in(lvl), .irq_valid_out(valid), .irq_vector_out(vec),
    .irq_level_out(level), .irq_fixed_out(fixed), .irq_source_out(src));
  core_sequencer_model core_sequencer_model_i (.core_clk_in(core_clk_in),
    .rstn_in(rstn_in), .irq_valid_in(valid), .irq_vector_in(vec),
    .taken_vector_out(taken), .taken_count_out(takes));
  // ==========================================================
  // reference model: {valid, vector, level, fixed, source}
  function automatic logic [33:0] model(input logic [23:0] b, input logic [5:0] f,
      input logic [35:0] r, input logic [35:0] e, input logic [71:0] l);
    int best;
    int lv;
    best = -1;
    lv = -1;
    for (int k = 5; k >= 0; k--) if (f[k]) best = k;
    if (best >= 0) return {1'b1, b + 24'(2 * best), 2'h3, 1'b1, 6'(best)};
    // scanning upward from the bottom lets the lower index win a tie
    for (int k = 35; k >= 0; k--) begin
      if (r[k] && e[k] && l[2*k+:2] != 2'h3 && int'(l[2*k+:2]) >= lv) begin
        lv = int'(l[2*k+:2]);
        best = k;
      end
    end
    if (best < 0) return {1'b0, b, 9'h000};
    return {1'b1, b + {16'h0000, ofs[best]}, 2'(lv), 1'b0, 6'(best)};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    n_tests++;
    if (seen !== want) begin
      n_errors++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  task automatic tick;
    @(posedge core_clk_in);
    #1;
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // clock and cycle ceiling
  initial forever #12.5 core_clk_in = ~core_clk_in;
  always @(posedge core_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_errors++;
      report_and_stop();
    end
  end
  // one-cycle latency model, compared at the falling edge
  always @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) expect_word <= '0;
    else expect_word <= model(base, fx, req, en, lvl);
  end
  always @(negedge core_clk_in) begin
    check({valid, vec}, expect_word[33:9]);
    check({level, fixed}, expect_word[8:6]);
    check(src, expect_word[5:0]);
  end
  // ==========================================================
  // scenarios
  initial begin
    void'($urandom(1));
    repeat (5) tick();
    rstn_in = 1;
    base = 24'h123456;
    en = '1;
    lvl = {36{2'h2}};
    fx[4] = 1;
    dma[0] = 1;
    tick();
    fx = 0;
    tick();
    dma = 0;
    repeat (2) tick();
    check(taken, base + 24'h000018);
    $display("test walk done");
    ext = '1;
    base = 24'hfffffa;
    for (int r = 0; r < 6; r++) begin
      fx = 6'h3f << r;
      tick();
    end
    fx = 0;
    $display("test fixed order done");
    {ext, dma, host, s0, s1, asp, tmr} = '1;
    for (int k = 0; k < 36; k++) begin
      en = 36'h1 << k;
      for (int v = 0; v < 4; v++) begin
        lvl = {$urandom, $urandom, 8'($urandom)};
        lvl[2*k+:2] = 2'(v);
        tick();
      end
      en = {36{1'b1}} << k;
      lvl = {36{2'h1}};
      tick();
    end
    // every maskable source requesting but all masked: nothing may show
    en = '0;
    repeat (2) tick();
    $display("test per source done");
    for (int i = 0; i < 3000; i++) begin
      base = 24'($urandom);
      fx = ($urandom % 8 == 0) ? 6'($urandom) : 6'h00;
      {ext, dma, host, s0, s1} = 25'($urandom);
      {asp, tmr} = 11'($urandom);
      en = {4'($urandom), $urandom} & {4'($urandom), $urandom};
      lvl = {$urandom, $urandom, 8'($urandom)};
      rstn_in = !(i >= 1500 && i < 1503);
      tick();
    end
    $display("test random done, core took %0d", takes);
    report_and_stop();
  end
endmodule // test_interrupt_vector_priority_logic
`default_nettype wire
